//--- mwc_bank.sv
// mwc_bank: wake-up filter loading, wake control/status, checksum offload control.
// assumes a single-cycle strobe master on core_clk; matchers live outside and
// report their hits as one-cycle event pulses.
// Notes on behaviour
// RULE1: filter writes land in the word the pointer selects, then pointer advances.
// RULE2: after the eighth filter word the pointer wraps to word zero.
// RULE3: filter load register is 32-bit write-only, filter words reset to zero.
// RULE4: with global unicast wake set, a unicast destination frame raises wake.
// RULE5: a matching remote wake frame sets the frame-received flag.
// RULE6: a valid wake packet sets the packet-received flag.
// RULE7: remote wake enable gates filter-based wake detection.
// RULE8: wake packet enable gates wake on address-repeat packets.
// RULE9: tx checksum enable zero bypasses the engine, one enables it.
// RULE10: software changes tx checksum enable only with the tx path off.
// RULE11: rx start mode zero starts at byte 14, one at layer-3 start.
// RULE12: software changes rx start mode only with the rx path off.
// RULE13: rx checksum enable zero bypasses the engine, one enables it.
// RULE14: software changes rx checksum enable only with the rx path off.
// RULE15: software never enables rx checksum and pad stripping together.
// RULE16: reserved control bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module mwc_bank
   import mwc_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic          clk_en,
   input  wire logic          soft_reset,
   input  wire logic [9:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [31:0]        reg_rdata,
   input  wire mwc_wake_evt_s wake_evt,
   output mwc_wake_cfg_s      wake_cfg,
   output mwc_csum_cfg_s      csum_cfg,
   output logic [7:0]         rx_start_offset,
   output logic [255:0]       wake_filter_words,
   output logic               wake_up,
   output logic               irq
);
   // filter store kept as an array; flattened to the matcher through a flop
   logic [31:0] wake_filter_word_q [MWC_FILTER_WORDS];
   logic [2:0]  ptr_q, ptr_d;
   logic [31:0] wake_csr_q, csum_q, mac_ctrl_q;
   logic [2:0]  irq_stat_q, irq_mask_q, irq_stat_d;
   logic [31:0] rdata_d;

   function automatic logic [31:0] masked_write(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [31:0] mask);
      masked_write = (new_v & mask) | (old_v & ~mask);
   endfunction

   // address decode
   wire wr_filter = reg_wr && (reg_addr == MWC_ADDR_FILTER_LOAD);
   wire wr_wake   = reg_wr && (reg_addr == MWC_ADDR_WAKE_CSR);
   wire wr_csum   = reg_wr && (reg_addr == MWC_ADDR_CSUM_CTRL);
   wire wr_istat  = reg_wr && (reg_addr == MWC_ADDR_IRQ_STATUS);
   wire wr_imask  = reg_wr && (reg_addr == MWC_ADDR_IRQ_MASK);
   wire wr_mac    = reg_wr && (reg_addr == MWC_ADDR_MAC_CTRL);
   wire any_reset = !reset_n || soft_reset;

   // qualified wake events; enables gate detection at the source
   wire frame_hit  = wake_evt.frame_match && wake_csr_q[MWC_REMOTE_WAKE_ENABLE_BIT];   // RULE7
   wire packet_hit = wake_evt.packet_match && wake_csr_q[MWC_WAKE_PACKET_ENABLE_BIT];  // RULE8
   wire uni_hit    = wake_evt.unicast_seen && wake_csr_q[MWC_GUE_BIT];   // RULE4
   wire wake_d     = frame_hit || packet_hit || uni_hit;

   // pointer steps once per filter write and wraps after the last word
   assign ptr_d = (ptr_q == MWC_PTR_LAST) ? MWC_PTR_RESET : ptr_q + 3'h1; // RULE2

   // sticky interrupt status; set beats a write-one clear in the same cycle
   assign irq_stat_d = (irq_stat_q & ~(wr_istat ? reg_wdata[2:0] : 3'h0))
                     | {uni_hit, packet_hit, frame_hit};

   // read mux; filter load reads zero since it is write-only
   assign rdata_d =
      (reg_addr == MWC_ADDR_WAKE_CSR)   ? wake_csr_q :
      (reg_addr == MWC_ADDR_CSUM_CTRL)  ? csum_q :
      (reg_addr == MWC_ADDR_IRQ_STATUS) ? {29'h0, irq_stat_q} :
      (reg_addr == MWC_ADDR_IRQ_MASK)   ? {29'h0, irq_mask_q} :
      (reg_addr == MWC_ADDR_MAC_CTRL)   ? mac_ctrl_q : 32'h00000000; // RULE3

   // filter pointer and storage
   always_ff @(posedge core_clk) begin
      if (any_reset) begin
         ptr_q <= MWC_PTR_RESET; // RULE1
         for (int i = 0; i < MWC_FILTER_WORDS; i++) begin
            wake_filter_word_q[i] <= MWC_RESET_WORD; // RULE3
         end
      end else if (clk_en && wr_filter) begin
         wake_filter_word_q[ptr_q] <= reg_wdata; // RULE1
         ptr_q                     <= ptr_d;
      end
   end

   // wake control/status: flags set by hardware, only enable bits writable
   always_ff @(posedge core_clk) begin
      if (any_reset) begin
         wake_csr_q <= MWC_RESET_WORD;
      end else if (clk_en) begin
         wake_csr_q <= masked_write(wake_csr_q, reg_wdata,
                                    wr_wake ? MWC_WAKE_CSR_WMASK : 32'h0); // RULE16
         if (frame_hit) wake_csr_q[MWC_WAKE_FRAME_RECEIVED_FLAG_BIT] <= 1'b1; // RULE5
         if (packet_hit) wake_csr_q[MWC_MPR_BIT] <= 1'b1; // RULE6
      end
   end

   // checksum and pad-strip control; software keeps them exclusive
   always_ff @(posedge core_clk) begin
      if (any_reset) begin
         csum_q     <= MWC_RESET_WORD;
         mac_ctrl_q <= MWC_RESET_WORD;
      end else if (clk_en) begin
         if (wr_csum) csum_q <= masked_write(csum_q, reg_wdata, MWC_CSUM_CTRL_WMASK); // RULE16
         if (wr_mac) mac_ctrl_q <= masked_write(mac_ctrl_q, reg_wdata, MWC_MAC_CTRL_WMASK);
      end
   end

   // interrupt status and mask
   always_ff @(posedge core_clk) begin
      if (any_reset) begin
         irq_stat_q <= MWC_IRQ_RESET;
         irq_mask_q <= MWC_IRQ_RESET;
      end else if (clk_en) begin
         irq_stat_q <= irq_stat_d;
         if (wr_imask) irq_mask_q <= reg_wdata[2:0];
      end
   end

   // registered outputs; engines see settings one cycle after the write
   always_ff @(posedge core_clk) begin
      if (any_reset) begin
         reg_rdata         <= MWC_RESET_WORD;
         wake_cfg          <= '0;
         csum_cfg          <= '0;
         rx_start_offset   <= MWC_RX_START_BYTES;
         wake_filter_words <= '0;
         wake_up           <= 1'b0;
         irq               <= 1'b0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
         wake_cfg  <= '{global_unicast_wake_enable: wake_csr_q[MWC_GUE_BIT],
                        remote_wake_enable:         wake_csr_q[MWC_REMOTE_WAKE_ENABLE_BIT],
                        wake_packet_enable:         wake_csr_q[MWC_WAKE_PACKET_ENABLE_BIT]};
         csum_cfg  <= '{tx_checksum_engine_enable: csum_q[MWC_TXEN_BIT],      // RULE9
                        rx_checksum_start_mode:    csum_q[MWC_RXMODE_BIT],
                        rx_checksum_engine_enable: csum_q[MWC_RXEN_BIT],      // RULE13
                        auto_pad_strip:            mac_ctrl_q[MWC_PAD_BIT]};  // RULE15
         // zero means layer-3 start found by the engine past tags/snap
         rx_start_offset <= csum_q[MWC_RXMODE_BIT] ? 8'h00 : MWC_RX_START_BYTES; // RULE11
         for (int i = 0; i < MWC_FILTER_WORDS; i++) begin
            wake_filter_words[32*i +: 32] <= wake_filter_word_q[i];
         end
         wake_up <= wake_d; // RULE4
         irq     <= |(irq_stat_d & irq_mask_q);
      end
   end
endmodule
`default_nettype wire

//--- mwc_bank_checker.sv
// mwc_bank_checker: port-level assertions for the wake / checksum bank.
// assumes it is bound onto mwc_bank; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mwc_bank_checker
   import mwc_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          reset_n,
   input wire logic          clk_en,
   input wire logic          soft_reset,
   input wire logic [9:0]    reg_addr,
   input wire logic [31:0]   reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [31:0]   reg_rdata,
   input wire mwc_wake_evt_s wake_evt,
   input wire mwc_wake_cfg_s wake_cfg,
   input wire mwc_csum_cfg_s csum_cfg,
   input wire logic [7:0]    rx_start_offset,
   input wire logic [255:0]  wake_filter_words,
   input wire logic          wake_up
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // live cycle; write data kept two deep since config outputs lag
   wire run = clk_en && !soft_reset;
   logic [31:0] wd1_q, wd2_q;
   always_ff @(posedge core_clk) begin
      wd1_q <= reg_wdata;
      wd2_q <= wd1_q;
   end
   sequence s_rd(a); run && reg_rd && reg_addr == a; endsequence
   sequence s_wr(a); run && reg_wr && reg_addr == a ##1 run && !reg_wr; endsequence
   // config settled: no write this cycle or the one before
   sequence s_calm; run && !reg_wr && !$past(reg_wr); endsequence
   property p_frame; s_calm and wake_evt.frame_match && wake_cfg.remote_wake_enable |=> wake_up; endproperty
   a_frame: assert property (p_frame) else $error("frame event gave no wake");
   property p_packet; s_calm and wake_evt.packet_match && wake_cfg.wake_packet_enable |=> wake_up; endproperty
   a_packet: assert property (p_packet) else $error("packet event gave no wake");
   property p_uni; s_calm and wake_evt.unicast_seen && wake_cfg.global_unicast_wake_enable |=> wake_up;
   endproperty
   a_uni: assert property (p_uni) else $error("unicast event gave no wake");
   property p_cause; wake_up && $past(clk_en) |-> $past(|wake_evt); endproperty
   a_cause: assert property (p_cause) else $error("wake without event");
   property p_filt_rd; s_rd(MWC_ADDR_FILTER_LOAD) |=> reg_rdata == 32'h0; endproperty
   a_filt_rd: assert property (p_filt_rd) else $error("filter load readable");
   property p_wake_rsv; s_rd(MWC_ADDR_WAKE_CSR) |=> (reg_rdata & ~32'h00000266) == 32'h0; endproperty
   a_wake_rsv: assert property (p_wake_rsv) else $error("wake reserved bit set");
   property p_wake_cfg; s_wr(MWC_ADDR_WAKE_CSR) |=> wake_cfg == {wd2_q[9], wd2_q[2], wd2_q[1]}; endproperty
   a_wake_cfg: assert property (p_wake_cfg) else $error("wake enables wrong");
   // engine enables and rx start mode follow the written bits 16, 1 and 0 two edges after the write
   property p_csum_cfg; s_wr(MWC_ADDR_CSUM_CTRL) |=> {csum_cfg.tx_checksum_engine_enable,
      csum_cfg.rx_checksum_start_mode, csum_cfg.rx_checksum_engine_enable} ==
      {wd2_q[16], wd2_q[1], wd2_q[0]}; endproperty
   a_csum_cfg: assert property (p_csum_cfg) else $error("checksum enables wrong");
   property p_offset; rx_start_offset == (csum_cfg.rx_checksum_start_mode ? 8'h00 : MWC_RX_START_BYTES);
   endproperty
   a_offset: assert property (p_offset) else $error("rx start offset wrong");
   property p_soft; soft_reset |=> wake_filter_words == 256'h0 && !wake_up; endproperty
   a_soft: assert property (p_soft) else $error("soft reset left state");
endmodule
bind mwc_bank mwc_bank_checker i_mwc_bank_checker (.*);
`default_nettype wire

//--- mwc_pkg.sv
// mwc_pkg: constants and carrier types for the wake-up / checksum control bank.
// assumes a plain strobe register port; offsets below are register indexes.
package mwc_pkg;
   // register indexes as printed; byte address is four times the index
   localparam logic [7:0] MWC_IDX_FILTER_LOAD = 8'h0B;
   localparam logic [7:0] MWC_IDX_WAKE_CSR    = 8'h0C;
   localparam logic [7:0] MWC_IDX_CSUM_CTRL   = 8'h0D;
   localparam logic [7:0] MWC_IDX_IRQ_STATUS  = 8'h20;
   localparam logic [7:0] MWC_IDX_IRQ_MASK    = 8'h21;
   localparam logic [7:0] MWC_IDX_MAC_CTRL    = 8'h22;
   localparam logic [9:0] MWC_ADDR_FILTER_LOAD = {MWC_IDX_FILTER_LOAD, 2'b00};
   localparam logic [9:0] MWC_ADDR_WAKE_CSR    = {MWC_IDX_WAKE_CSR, 2'b00};
   localparam logic [9:0] MWC_ADDR_CSUM_CTRL   = {MWC_IDX_CSUM_CTRL, 2'b00};
   localparam logic [9:0] MWC_ADDR_IRQ_STATUS  = {MWC_IDX_IRQ_STATUS, 2'b00};
   localparam logic [9:0] MWC_ADDR_IRQ_MASK    = {MWC_IDX_IRQ_MASK, 2'b00};
   localparam logic [9:0] MWC_ADDR_MAC_CTRL    = {MWC_IDX_MAC_CTRL, 2'b00};

   // wake control / status fields
   localparam int MWC_GUE_BIT  = 9;
   localparam int MWC_WAKE_FRAME_RECEIVED_FLAG_BIT = 6;
   localparam int MWC_MPR_BIT  = 5;
   localparam int MWC_REMOTE_WAKE_ENABLE_BIT = 2;
   localparam int MWC_WAKE_PACKET_ENABLE_BIT = 1;
   // checksum control fields
   localparam int MWC_TXEN_BIT   = 16;
   localparam int MWC_RXMODE_BIT = 1;
   localparam int MWC_RXEN_BIT   = 0;
   // mac control pad strip position
   localparam int MWC_PAD_BIT = 8;
   // interrupt status / mask layout
   localparam int MWC_IRQ_FRAME_BIT  = 0;
   localparam int MWC_IRQ_PACKET_BIT = 1;
   localparam int MWC_IRQ_UNI_BIT    = 2;

   localparam logic [31:0] MWC_WAKE_CSR_WMASK  = 32'h00000206;
   localparam logic [31:0] MWC_CSUM_CTRL_WMASK = 32'h00010003;
   localparam logic [31:0] MWC_MAC_CTRL_WMASK  = 32'h00000100;
   localparam logic [31:0] MWC_RESET_WORD      = 32'h00000000;
   localparam logic [2:0]  MWC_IRQ_RESET       = 3'h0;

   localparam int          MWC_FILTER_WORDS = 8;
   localparam logic [2:0]  MWC_PTR_RESET    = 3'h0;
   localparam logic [2:0]  MWC_PTR_LAST     = 3'h7;
   // rx checksum start offset in mode 0, in bytes
   localparam logic [7:0]  MWC_RX_START_BYTES = 8'h0E;

   typedef struct packed {
      logic       global_unicast_wake_enable;
      logic       remote_wake_enable;
      logic       wake_packet_enable;
   } mwc_wake_cfg_s;

   typedef struct packed {
      logic       tx_checksum_engine_enable;
      logic       rx_checksum_start_mode;
      logic       rx_checksum_engine_enable;
      logic       auto_pad_strip;
   } mwc_csum_cfg_s;

   typedef struct packed {
      logic       frame_match;
      logic       packet_match;
      logic       unicast_seen;
   } mwc_wake_evt_s;
endpackage

//--- tb_top.sv
// tb_top: self-checking bench for the wake / checksum register bank.
// assumes mwc_pkg and mwc_bank compiled first; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mwc_pkg::*;
;
   logic          core_clk = 0, reset_n = 0, clk_en = 1, soft_reset = 0, reg_wr = 0, reg_rd = 0;
   logic [9:0]    reg_addr = '0;
   logic [31:0]   reg_wdata = '0, reg_rdata, seed = 32'h00005319, v [9];
   logic          wake_up, irq;
   mwc_wake_evt_s wake_evt = '0;
   mwc_wake_cfg_s wake_cfg;
   mwc_csum_cfg_s csum_cfg;
   logic [7:0]    rx_start_offset;
   logic [255:0]  wake_filter_words;
   int            bad_count = 0, checks = 0, cyc = 0;
   mwc_bank i_mwc_bank (.*);
   always #2.5 core_clk = ~core_clk;
   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] offset_of(input logic [31:0] d);
      return d[1] ? 32'h0 : 32'h0E;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 chk(n, e, reg_rdata);
   endtask
   task automatic ev(input logic [2:0] e, input logic w);
      @(posedge core_clk);
      wake_evt <= e;
      @(posedge core_clk);
      wake_evt <= '0;
      #1 chk("wake_up", {31'h0, w}, {31'h0, wake_up});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'h1;
      rd(MWC_ADDR_FILTER_LOAD, 32'h0, "filter_rd");
      rd(10'h3FC, 32'h0, "unmapped");
      chk("offset", 32'h0E, {24'h0, rx_start_offset});
      // nine loads: the ninth lands back on word zero
      for (int i = 0; i < 9; i++) begin
         v[i] = rnd();
         wr(MWC_ADDR_FILTER_LOAD, v[i]);
      end
      @(posedge core_clk);
      #1 chk("filter_wrap", v[8], wake_filter_words[31:0]);
      for (int i = 1; i < 8; i++) chk("filter_word", v[i], wake_filter_words[32*i +: 32]);
      soft_reset <= 1'h1;
      @(posedge core_clk);
      soft_reset <= 1'h0;
      v[0] = rnd();
      wr(MWC_ADDR_FILTER_LOAD, v[0]);
      @(posedge core_clk);
      #1 chk("ptr_reset", v[0], wake_filter_words[31:0]);
      $display("test filter done");
      for (int i = 0; i < 6; i++) begin
         v[0] = (i == 0) ? 32'hFFFFFFFF : rnd();
         wr(MWC_ADDR_WAKE_CSR, v[0]);
         rd(MWC_ADDR_WAKE_CSR, v[0] & MWC_WAKE_CSR_WMASK, "wake_csr");
         wr(MWC_ADDR_CSUM_CTRL, v[0]);
         rd(MWC_ADDR_CSUM_CTRL, v[0] & MWC_CSUM_CTRL_WMASK, "csum_ctrl");
         chk("offset", offset_of(v[0]), {24'h0, rx_start_offset});
      end
      $display("test registers done");
      wr(MWC_ADDR_IRQ_MASK, 32'h7);
      wr(MWC_ADDR_WAKE_CSR, 32'h206);
      for (int i = 0; i < 3; i++) ev(3'h1 << i, 1'h1);
      chk("irq", 32'h1, {31'h0, irq});
      rd(MWC_ADDR_WAKE_CSR, 32'h266, "wake_flags");
      wr(MWC_ADDR_WAKE_CSR, 32'h0);
      wr(MWC_ADDR_IRQ_STATUS, 32'h7);
      for (int i = 0; i < 3; i++) ev(3'h1 << i, 1'h0);
      chk("irq_clr", 32'h0, {31'h0, irq});
      rd(MWC_ADDR_WAKE_CSR, 32'h60, "sticky");
      wr(MWC_ADDR_IRQ_MASK, 32'h0);
      wr(MWC_ADDR_WAKE_CSR, 32'h4);
      ev(3'h4, 1'h1);
      chk("irq_mask", 32'h0, {31'h0, irq});
      rd(MWC_ADDR_IRQ_STATUS, 32'h1, "irq_status");
      // clock enable low must swallow a write
      clk_en <= 1'h0;
      wr(MWC_ADDR_IRQ_MASK, 32'h7);
      clk_en <= 1'h1;
      rd(MWC_ADDR_IRQ_MASK, 32'h0, "frozen_mask");
      $display("test events done");
      print_verdict();
   end
endmodule
`default_nettype wire
